// ===== src/dshp_dma_pulse.sv
// one dma request pulse generator
// assumes trigger is a one-cycle event in the core clock domain
`timescale 1ns/1ps
module dshp_dma_pulse
  import dshp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic trigger_i,
  output logic request_n_o
);
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;

  // triggers during a running pulse merge into it
  always_comb begin
    cnt_d = cnt_q;
    if (cnt_q != 2'h0) begin
      cnt_d = cnt_q - 2'h1;
    end else if (trigger_i) begin
      cnt_d = 2'(DMA_PULSE_CYC);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
      request_n_o <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      request_n_o <= (cnt_d == 2'h0);
    end
  end

  chk_pulse_width: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $fell(request_n_o) |-> !request_n_o [*3] ##1 request_n_o)
    else $error("dma request pulse not three cycles");
endmodule

// ===== src/dshp_host_port.sv
// host bus port: register access, vectored interrupt chain, dma requests, resets
// assumes address, direction and data inputs are stable while a strobe is low
`timescale 1ns/1ps
module dshp_host_port
  import dshp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic hw_rst_n_i,
  input wire logic cs_n_i,
  input wire logic rw_i,
  input wire logic [4:0] register_select_lines_i,
  input wire logic [7:0] bus_data_lines_i,
  output logic [7:0] bus_data_lines_o,
  output logic bus_data_lines_oe_o,
  output logic transfer_ack_n_o,
  output logic transfer_ack_n_oe_o,
  input wire logic int_ack_n_i,
  output logic int_request_n_o,
  output logic int_request_n_oe_o,
  input wire logic chain_enable_in_n_i,
  output logic chain_enable_out_n_o,
  output logic [1:0] tx_dma_request_n_o,
  output logic [1:0] rx_dma_request_n_o,
  input wire logic [1:0] cts_n_i,
  input wire logic [1:0] carrier_detect_in_n_i,
  input wire logic [1:0] rx_char_valid_i,
  input wire logic [15:0] rx_char_i,
  input wire logic [7:0] rx_err_i,
  input wire logic [1:0] rx_special_i,
  input wire logic [1:0] rx_break_i,
  input wire logic [1:0] rx_hunt_i,
  input wire logic [1:0] tx_underrun_i,
  input wire logic [1:0] tx_buffer_empty_i,
  input wire logic [1:0] tx_all_sent_i,
  output logic [15:0] tx_data_o,
  output logic [1:0] tx_load_o,
  output logic [1:0] tx_marking_o,
  output logic [1:0] tx_bit_clock_pin_oe_o,
  output logic [1:0] rx_bit_clock_pin_oe_o,
  output logic [1:0] sync_pin_oe_o
);
  logic rst;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // reset and strobe synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_sync_q;
  logic [1:0] int_ack_n_sync_q;
  logic cs_prev_q;
  logic int_ack_n_prev_q;
  logic cs_fall;
  logic int_ack_n_fall;
  logic cs_high;
  logic int_ack_n_high;

  assign rst = sys_rst_i || !hw_rst_n_i;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      cs_sync_q <= 2'h3;
      int_ack_n_sync_q <= 2'h3;
      cs_prev_q <= 1'b1;
      int_ack_n_prev_q <= 1'b1;
    end else begin
      cs_sync_q <= {cs_sync_q[0], cs_n_i};
      int_ack_n_sync_q <= {int_ack_n_sync_q[0], int_ack_n_i};
      cs_prev_q <= cs_sync_q[1];
      int_ack_n_prev_q <= int_ack_n_sync_q[1];
    end
  end

  // one strobe edge starts at most one cycle of work
  assign cs_fall = cs_prev_q && !cs_sync_q[1];
  assign int_ack_n_fall = int_ack_n_prev_q && !int_ack_n_sync_q[1];
  assign cs_high = cs_sync_q[1];
  assign int_ack_n_high = int_ack_n_sync_q[1];

  // ---------------------------------------------------------------
  // shared state and decode
  // ---------------------------------------------------------------
  dshp_bus_state_t st_q;
  logic is_int_ack_n_q;
  logic is_read_q;
  logic [NUM_SRC-1:0] pend_q;
  logic [NUM_SRC-1:0] frozen_q;
  logic [NUM_SRC-1:0] served_q;
  logic [NUM_SRC-1:0] pend_set;
  logic [NUM_SRC-1:0] pend_chrst;
  logic [7:0] vec_q;
  logic [7:0] rd_chan [NUM_CHAN];
  logic [7:0] intctl [NUM_CHAN];
  logic [1:0] chan_rst;
  logic [3:0] idx;
  logic sel_ch;
  logic start_rd;
  logic start_wr;
  logic serve_done;
  logic [7:0] rd_data;

  assign idx = register_select_lines_i[3:0];
  assign sel_ch = register_select_lines_i[CHAN_SEL_BIT];
  // the host keeps select and acknowledge apart; select is served first
  assign start_rd = (st_q == BUS_IDLE) && cs_fall && rw_i;
  assign start_wr = (st_q == BUS_IDLE) && cs_fall && !rw_i;
  assign serve_done = (st_q == BUS_DEASSERT) && is_int_ack_n_q;

  function automatic logic [VEC_CODE_W-1:0] top_src(input logic [NUM_SRC-1:0] p);
    top_src = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        top_src = VEC_CODE_W'(i);
      end
    end
  endfunction

  // status-affects-vector is taken from the first channel's control register
  function automatic logic [7:0] vec_for(input logic [NUM_SRC-1:0] p, input logic [7:0] v, input logic sav);
    return sav ? {v[7:VEC_CODE_W], top_src(p)} : v;
  endfunction

  function automatic logic [NUM_SRC-1:0] onehot_top(input logic [NUM_SRC-1:0] p);
    return NUM_SRC'(1) << top_src(p);
  endfunction

  assign rd_data = (idx == IDX_VEC) ? vec_for(pend_q, vec_q, intctl[0][ICTL_SAV]) : rd_chan[sel_ch];

  // ---------------------------------------------------------------
  // bus cycle sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      st_q <= BUS_IDLE;
      is_int_ack_n_q <= 1'b0;
      is_read_q <= 1'b0;
      frozen_q <= '0;
      served_q <= '0;
      bus_data_lines_o <= 8'h00;
      bus_data_lines_oe_o <= 1'b0;
      transfer_ack_n_o <= 1'b1;
      transfer_ack_n_oe_o <= 1'b0;
    end else begin
      unique case (st_q)
        BUS_IDLE: begin
          if (cs_fall) begin
            is_int_ack_n_q <= 1'b0;
            is_read_q <= rw_i;
            if (rw_i) begin
              bus_data_lines_o <= rd_data;
              bus_data_lines_oe_o <= 1'b1;
            end
            st_q <= BUS_DRIVE;
          end else if (int_ack_n_fall) begin
            is_int_ack_n_q <= 1'b1;
            is_read_q <= 1'b0;
            frozen_q <= pend_q;
            st_q <= BUS_CHAIN;
          end
        end
        BUS_CHAIN: begin
          if (int_ack_n_high) begin
            st_q <= BUS_IDLE;
          end else if (!chain_enable_in_n_i && (frozen_q != '0)) begin
            bus_data_lines_o <= vec_for(frozen_q, vec_q, intctl[0][ICTL_SAV]);
            bus_data_lines_oe_o <= 1'b1;
            served_q <= onehot_top(frozen_q);
            st_q <= BUS_DRIVE;
          end
        end
        BUS_DRIVE: begin
          // data has stood one cycle before acknowledge falls
          transfer_ack_n_o <= 1'b0;
          transfer_ack_n_oe_o <= 1'b1;
          st_q <= BUS_ACK;
        end
        BUS_ACK: begin
          if (is_int_ack_n_q ? int_ack_n_high : cs_high) begin
            transfer_ack_n_o <= 1'b1;
            st_q <= BUS_DEASSERT;
          end
        end
        BUS_DEASSERT: begin
          transfer_ack_n_oe_o <= 1'b0;
          bus_data_lines_oe_o <= 1'b0;
          st_q <= BUS_IDLE;
        end
        default: begin
          st_q <= BUS_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // interrupt pending, request and chain
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      pend_q <= '0;
    end else begin
      // a new event beats a clear in the same cycle
      pend_q <= (pend_q & ~pend_chrst & ~(serve_done ? served_q : '0)) | pend_set;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      int_request_n_oe_o <= 1'b0;
      int_request_n_o <= 1'b1;
    end else begin
      // released while a vector is being passed, back once the cycle ends
      int_request_n_oe_o <= (pend_q != '0) && !(is_int_ack_n_q && (st_q inside {BUS_DRIVE, BUS_ACK, BUS_DEASSERT}));
      int_request_n_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      chain_enable_out_n_o <= 1'b1;
    end else begin
      chain_enable_out_n_o <= !((st_q == BUS_CHAIN) && !int_ack_n_high && !chain_enable_in_n_i && (frozen_q == '0));
    end
  end

  // ---------------------------------------------------------------
  // shared vector register
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst) begin
      vec_q <= VEC_RESET;
    end else if (start_wr && (idx == IDX_VEC)) begin
      vec_q <= bus_data_lines_i;
    end
  end

  // ---------------------------------------------------------------
  // per-channel registers, status, queue and dma
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    logic [7:0] ctl_q [NUM_CTL];
    logic [7:0] rd_val;
    logic [7:0] stat0;
    logic [7:0] stat1;
    logic [RX_ENTRY_W-1:0] head;
    logic avail;
    logic wr_here;
    logic tx_empty_q;
    logic all_sent_q;
    logic break_q;
    logic hunt_q;
    logic underrun_q;
    logic cts_q;
    logic dcd_q;
    logic special_hit;
    logic rx_dma_trig;
    logic tx_dma_trig;
    logic [7:0] tx_data_q;
    logic tx_load_q;
    logic mark_q;
    logic txc_oe_q;
    logic rxc_oe_q;
    logic sync_oe_q;

    assign wr_here = start_wr && (sel_ch == 1'(ch));
    assign chan_rst[ch] = rst || (wr_here && (idx == IDX_CMD) && (bus_data_lines_i == CMD_CHAN_RESET));
    assign intctl[ch] = ctl_q[IDX_INTCTL];

    always_ff @(posedge core_clk_i) begin
      if (chan_rst[ch]) begin
        for (int i = 0; i < NUM_CTL; i++) begin
          ctl_q[i] <= RW_RESET;
        end
      end else if (wr_here && dshp_is_rw(idx)) begin
        ctl_q[idx] <= bus_data_lines_i;
      end
    end

    // transmit buffer survives a channel reset
    always_ff @(posedge core_clk_i) begin
      if (rst) begin
        tx_data_q <= 8'h00;
        tx_load_q <= 1'b0;
      end else begin
        tx_load_q <= wr_here && (idx == IDX_DATA);
        if (wr_here && (idx == IDX_DATA)) begin
          tx_data_q <= bus_data_lines_i;
        end
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (chan_rst[ch]) begin
        tx_empty_q <= 1'b1;
        all_sent_q <= 1'b1;
        break_q <= 1'b0;
        hunt_q <= 1'b1;
        underrun_q <= 1'b1;
      end else begin
        tx_empty_q <= tx_buffer_empty_i[ch] || (tx_empty_q && !tx_load_q);
        all_sent_q <= tx_all_sent_i[ch] || (all_sent_q && !tx_load_q);
        break_q <= rx_break_i[ch];
        hunt_q <= rx_hunt_i[ch];
        underrun_q <= tx_underrun_i[ch];
      end
    end

    // modem flags show the inverted pin level, at reset and after
    always_ff @(posedge core_clk_i) begin
      cts_q <= !cts_n_i[ch];
      dcd_q <= !carrier_detect_in_n_i[ch];
    end

    assign stat0 = {break_q, underrun_q, cts_q, hunt_q, dcd_q, tx_empty_q,
                    (pend_q[ch*SRC_PER_CHAN +: SRC_PER_CHAN] != '0), avail};
    assign stat1 = {(avail ? head[RX_ENTRY_W-1 -: RX_ERR_W] : 4'h0), 3'h0, all_sent_q};

    always_comb begin
      rd_val = UNMAPPED_READ;
      if (dshp_is_rw(idx)) begin
        rd_val = ctl_q[idx];
      end else if (idx == IDX_STAT0) begin
        rd_val = stat0;
      end else if (idx == IDX_STAT1) begin
        rd_val = stat1;
      end else if (idx == IDX_DATA) begin
        rd_val = head[7:0];
      end
    end
    assign rd_chan[ch] = rd_val;

    dshp_rx_fifo u_rx_fifo (
      .core_clk_i(core_clk_i),
      .rst_i(rst),
      .flush_i(chan_rst[ch]),
      .push_i(rx_char_valid_i[ch]),
      .push_data_i({rx_err_i[ch*RX_ERR_W +: RX_ERR_W], rx_char_i[ch*8 +: 8]}),
      .pop_i(start_rd && (sel_ch == 1'(ch)) && (idx == IDX_DATA)),
      .head_o(head),
      .avail_o(avail)
    );

    // special condition under first-character mode replaces the dma request
    assign special_hit = rx_special_i[ch] && intctl[ch][ICTL_FIRST_ONLY] && intctl[ch][ICTL_RX_DMA_EN];
    assign rx_dma_trig = rx_char_valid_i[ch] && intctl[ch][ICTL_RX_DMA_EN] && !special_hit;
    assign tx_dma_trig = tx_buffer_empty_i[ch] && intctl[ch][ICTL_TX_DMA_EN];

    assign pend_set[ch*SRC_PER_CHAN + SRC_SPECIAL] = special_hit;
    assign pend_set[ch*SRC_PER_CHAN + SRC_RX] = rx_char_valid_i[ch] && intctl[ch][ICTL_RX_INT_EN];
    assign pend_set[ch*SRC_PER_CHAN + SRC_TX] = tx_buffer_empty_i[ch] && intctl[ch][ICTL_TX_INT_EN];
    assign pend_chrst[ch*SRC_PER_CHAN +: SRC_PER_CHAN] = {SRC_PER_CHAN{chan_rst[ch]}};

    dshp_dma_pulse u_tx_dma (
      .core_clk_i(core_clk_i),
      .rst_i(chan_rst[ch]),
      .trigger_i(tx_dma_trig),
      .request_n_o(tx_dma_request_n_o[ch])
    );

    dshp_dma_pulse u_rx_dma (
      .core_clk_i(core_clk_i),
      .rst_i(chan_rst[ch]),
      .trigger_i(rx_dma_trig),
      .request_n_o(rx_dma_request_n_o[ch])
    );

    always_ff @(posedge core_clk_i) begin
      if (chan_rst[ch]) begin
        mark_q <= 1'b1;
        txc_oe_q <= 1'b0;
        rxc_oe_q <= 1'b0;
        sync_oe_q <= 1'b1;
      end else begin
        mark_q <= !ctl_q[IDX_XMTCTL][XMT_TX_EN];
        txc_oe_q <= ctl_q[IDX_BRG][BRG_TXC_OUT];
        rxc_oe_q <= ctl_q[IDX_BRG][BRG_RXC_OUT];
        sync_oe_q <= !ctl_q[IDX_MODE][MODE_SYNC_IN];
      end
    end

    assign tx_data_o[ch*8 +: 8] = tx_data_q;
    assign tx_load_o[ch] = tx_load_q;
    assign tx_marking_o[ch] = mark_q;
    assign tx_bit_clock_pin_oe_o[ch] = txc_oe_q;
    assign rx_bit_clock_pin_oe_o[ch] = rxc_oe_q;
    assign sync_pin_oe_o[ch] = sync_oe_q;

    chk_stat1_reset: assert property ($past(chan_rst[ch]) |-> (stat1 == 8'h01))
      else $error("second status not 01h after channel reset");
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_read_data_first: assert property ($fell(transfer_ack_n_o) && is_read_q |->
    bus_data_lines_oe_o && $past(bus_data_lines_oe_o))
    else $error("acknowledge fell before read data stood");
  chk_unmapped_reads_ff: assert property (start_rd && (idx > IDX_VEC) |=>
    (bus_data_lines_o == UNMAPPED_READ) && bus_data_lines_oe_o)
    else $error("unmapped read did not drive ffh");
  chk_release_after_ack: assert property ($rose(transfer_ack_n_o) |=>
    !transfer_ack_n_oe_o && !bus_data_lines_oe_o)
    else $error("lines not released after acknowledge rose");
  chk_vector_write: assert property (start_wr && (idx == IDX_VEC) |=>
    vec_q == $past(bus_data_lines_i))
    else $error("vector write not stored");
  chk_irq_released: assert property (is_int_ack_n_q && (st_q == BUS_ACK) |-> int_request_n_oe_o == 1'b0)
    else $error("request held during vector transfer");
  chk_idle_int_ack_n_float: assert property ((st_q == BUS_CHAIN) && (frozen_q == '0) |->
    !transfer_ack_n_oe_o && !bus_data_lines_oe_o)
    else $error("answered acknowledge with nothing pending");
  chk_chain_out_low: assert property (!chain_enable_out_n_o |->
    $past((st_q == BUS_CHAIN) && !chain_enable_in_n_i && (frozen_q == '0) && !int_ack_n_high))
    else $error("chain output low without cause");
  chk_vector_reset: assert property (@(posedge core_clk_i) $past(rst) && !rst |-> vec_q == VEC_RESET)
    else $error("vector not 0fh after reset");
endmodule

// ===== src/dshp_pkg.sv
// constants, field positions and bus states of the dual serial host bus port
// assumes the host keeps select and interrupt acknowledge apart
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package dshp_pkg;
  localparam logic [3:0] IDX_CMD = 4'h0;
  localparam logic [3:0] IDX_MODE = 4'h1;
  localparam logic [3:0] IDX_INTCTL = 4'h2;
  localparam logic [3:0] IDX_XMTCTL = 4'h6;
  localparam logic [3:0] IDX_STAT0 = 4'h7;
  localparam logic [3:0] IDX_STAT1 = 4'h8;
  localparam logic [3:0] IDX_DATA = 4'h9;
  localparam logic [3:0] IDX_TC = 4'ha;
  localparam logic [3:0] IDX_BRG = 4'hb;
  localparam logic [3:0] IDX_VEC = 4'hc;
  localparam int CHAN_SEL_BIT = 4;
  localparam int NUM_CTL = 12;
  localparam logic [7:0] CMD_CHAN_RESET = 8'h18;
  localparam logic [7:0] RW_RESET = 8'h00;
  localparam logic [7:0] VEC_RESET = 8'h0f;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  // interrupt control fields
  localparam int ICTL_SAV = 0;
  localparam int ICTL_RX_INT_EN = 1;
  localparam int ICTL_TX_INT_EN = 2;
  localparam int ICTL_RX_DMA_EN = 3;
  localparam int ICTL_TX_DMA_EN = 4;
  localparam int ICTL_FIRST_ONLY = 5;
  localparam int MODE_SYNC_IN = 0;
  localparam int XMT_TX_EN = 0;
  localparam int BRG_TXC_OUT = 0;
  localparam int BRG_RXC_OUT = 1;
  localparam int ST1_ERR_LSB = 4;
  localparam int VEC_CODE_W = 3;
  localparam int NUM_CHAN = 2;
  localparam int SRC_PER_CHAN = 3;
  localparam int NUM_SRC = 6;
  localparam int SRC_SPECIAL = 0;
  localparam int SRC_RX = 1;
  localparam int SRC_TX = 2;
  localparam int DMA_PULSE_CYC = 3;
  localparam int RX_FIFO_DEPTH = 3;
  localparam int RX_ERR_W = 4;
  localparam int RX_ENTRY_W = 12;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_CHAIN,
    BUS_DRIVE,
    BUS_ACK,
    BUS_DEASSERT
  } dshp_bus_state_t;

  function automatic logic dshp_is_rw(input logic [3:0] idx);
    return (idx <= IDX_XMTCTL) || (idx == IDX_TC) || (idx == IDX_BRG);
  endfunction
endpackage

// ===== src/dshp_rx_fifo.sv
// three-entry receive queue, data with its error bits
// assumes pushes come one per cycle from the receiver
`timescale 1ns/1ps
module dshp_rx_fifo
  import dshp_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [RX_ENTRY_W-1:0] push_data_i,
  input wire logic pop_i,
  output logic [RX_ENTRY_W-1:0] head_o,
  output logic avail_o
);
  logic [RX_ENTRY_W-1:0] mem_q [RX_FIFO_DEPTH];
  logic [1:0] wr_ptr_q;
  logic [1:0] rd_ptr_q;
  logic [1:0] count_q;
  logic do_push;
  logic do_pop;

  function automatic logic [1:0] nxt(input logic [1:0] p);
    return (p == 2'(RX_FIFO_DEPTH - 1)) ? 2'h0 : p + 2'h1;
  endfunction

  // a character arriving on a full queue is dropped
  assign do_push = push_i && (count_q != 2'(RX_FIFO_DEPTH));
  assign do_pop = pop_i && (count_q != 2'h0);

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < RX_FIFO_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (do_push) begin
      mem_q[wr_ptr_q] <= push_data_i;
    end
  end

  // flush clears the count and both pointers; stored bytes stay in place
  always_ff @(posedge core_clk_i) begin
    if (flush_i) begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
      count_q <= 2'h0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= nxt(wr_ptr_q);
      end
      if (do_pop) begin
        rd_ptr_q <= nxt(rd_ptr_q);
      end
      count_q <= count_q + 2'(do_push) - 2'(do_pop);
    end
  end

  assign head_o = mem_q[rd_ptr_q];
  assign avail_o = (count_q != 2'h0);
endmodule

// ===== test/dshp_host_model.sv
// host cpu model: one select or acknowledge cycle at a time
// assumes acknowledge and data arrive already resolved with pull-ups
`timescale 1ns/1ps
module dshp_host_model (
  input wire logic core_clk_i,
  input wire logic ack_n_i,
  input wire logic [7:0] data_i,
  output logic cs_n_o,
  output logic int_ack_n_n_o,
  output logic rw_o,
  output logic [4:0] addr_o,
  output logic [7:0] wdata_o,
  output logic drive_o
);
  initial begin
    cs_n_o = 1'b1;
    int_ack_n_n_o = 1'b1;
    rw_o = 1'b1;
    addr_o = 5'h00;
    wdata_o = 8'h00;
    drive_o = 1'b0;
  end
  // only one strobe per call, so select and acknowledge never overlap
  task automatic cycle(input logic ia, input logic rd, input logic [4:0] a, input logic [7:0] wd,
    output logic [7:0] q, output logic ok);
    int n;
    n = 0;
    @(negedge core_clk_i);
    rw_o = rd;
    addr_o = a;
    wdata_o = wd;
    drive_o = !rd && !ia;
    if (ia) int_ack_n_n_o = 1'b0;
    else cs_n_o = 1'b0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (ack_n_i !== 1'b0 && n < 20);
    q = data_i;
    ok = (ack_n_i === 1'b0);
    cs_n_o = 1'b1;
    int_ack_n_n_o = 1'b1;
    drive_o = 1'b0;
    repeat (8) @(negedge core_clk_i);
  endtask
endmodule

// ===== test/dshp_host_port_bench.sv
// self-checking bench of the host bus port
// assumes the host model drives strobes at falling edges
`timescale 1ns/1ps
module dshp_host_port_bench;
  import dshp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, int_ack_n_n, rw, drv, ack, ack_oe, d_oe, rq, rq_oe, ceo, ok;
  logic [4:0] ad;
  logic [7:0] wd, d_o, v, d, q, w;
  logic hw_n = 1'b1;
  logic cei = 1'b0;
  logic ceo_seen = 1'b0;
  logic [1:0] rsp, mark, tx_bit_clock_pin, rco, syn, tx_ld;
  logic [15:0] txd;
  int n_load = 0;
  int n_rxp = 0;
  logic [1:0] tx_rq, rx_rq, rxv, txe, lv;
  logic [15:0] rx_bit_clock_pin;
  logic [7:0] bus, rxe;
  int err_count = 0;
  int n_tests = 0;
  int cnt;
  int rxq[$];
  assign bus = d_oe ? d_o : (drv ? wd : 8'hff);
  always #2 clk = ~clk;
  dshp_host_port i_dut (.core_clk_i(clk), .sys_rst_i(rst), .hw_rst_n_i(hw_n), .cs_n_i(cs_n), .rw_i(rw),
    .register_select_lines_i(ad), .bus_data_lines_i(bus), .bus_data_lines_o(d_o), .bus_data_lines_oe_o(d_oe),
    .transfer_ack_n_o(ack), .transfer_ack_n_oe_o(ack_oe), .int_ack_n_i(int_ack_n_n), .int_request_n_o(rq),
    .int_request_n_oe_o(rq_oe), .chain_enable_in_n_i(cei), .chain_enable_out_n_o(ceo),
    .tx_dma_request_n_o(tx_rq), .rx_dma_request_n_o(rx_rq), .cts_n_i(lv), .carrier_detect_in_n_i(~lv),
    .rx_char_valid_i(rxv), .rx_char_i(rx_bit_clock_pin), .rx_err_i(rxe), .rx_special_i(rsp), .rx_break_i(lv),
    .rx_hunt_i(lv), .tx_underrun_i(~lv), .tx_buffer_empty_i(txe), .tx_all_sent_i(2'b00), .tx_data_o(txd),
    .tx_load_o(tx_ld), .tx_marking_o(mark), .tx_bit_clock_pin_oe_o(tx_bit_clock_pin), .rx_bit_clock_pin_oe_o(rco),
    .sync_pin_oe_o(syn));
  // channel 0 load and receive dma request and the chain output are caught here so the scenarios need not poll them
  always @(negedge clk) begin
    if (ceo === 1'b0) ceo_seen = 1'b1;
    n_load += (tx_ld[0] === 1'b1);
    n_rxp += (rx_rq[0] === 1'b0);
  end
  dshp_host_model i_host (.core_clk_i(clk), .ack_n_i(ack_oe ? ack : 1'b1), .data_i(bus), .cs_n_o(cs_n),
    .int_ack_n_n_o(int_ack_n_n), .rw_o(rw), .addr_o(ad), .wdata_o(wd), .drive_o(drv));
  task automatic close_out();
    $display("counts: %0d compares, %0d mismatches", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic ia, input logic r, input logic [4:0] a, input logic [7:0] x);
    i_host.cycle(ia, r, a, x, q, ok);
    if (!ok) begin
      err_count++;
      $display("MISMATCH %0t no acknowledge", $time);
      close_out();
    end
  endtask
  task automatic rx_pulse(input logic [1:0] sp);
    @(negedge clk) begin
      rxv = 2'b01;
      rsp = sp;
    end
    @(negedge clk) begin
      rxv = 2'b00;
      rsp = 2'b00;
    end
    repeat (6) @(negedge clk);
  endtask
  initial begin
    rxv = 2'b00;
    txe = 2'b00;
    rsp = 2'b00;
    rx_bit_clock_pin = 16'h0000;
    void'($urandom(32'h65ebd04e));
    lv = 2'($urandom);
    rxe = 8'($urandom);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
    acc(0, 1, 5'h0c, 8'h00); chk(q, VEC_RESET);
    acc(0, 1, 5'h0d, 8'h00); chk(q, 8'hff);
    acc(0, 1, 5'h08, 8'h00); chk(q, 8'h01);
    $display("test 1 done");
    v = 8'($urandom);
    d = 8'($urandom) & 8'h3e;
    acc(0, 0, 5'h0c, v);
    acc(0, 1, 5'h1c, 8'h00); chk(q, v);
    acc(0, 0, 5'h02, d);
    acc(0, 1, 5'h02, 8'h00); chk(q, d);
    w = 8'($urandom);
    acc(0, 0, 5'h06, 8'h01);
    acc(0, 0, 5'h0b, 8'h03);
    acc(0, 0, 5'h01, 8'h01);
    acc(0, 0, 5'h09, w);
    chk({4'h0, mark[0], tx_bit_clock_pin[0], rco[0], syn[0]}, 8'h06);
    chk(txd[7:0], w);
    chk(8'(n_load), 8'h01);
    acc(0, 0, 5'h00, CMD_CHAN_RESET);
    acc(0, 1, 5'h02, 8'h00); chk(q, RW_RESET);
    acc(0, 1, 5'h0c, 8'h00); chk(q, v);
    chk({4'h0, mark[0], tx_bit_clock_pin[0], rco[0], syn[0]}, 8'h09);
    chk(txd[7:0], w);
    $display("test 2 done");
    acc(0, 0, 5'h12, 8'h10);
    @(negedge clk) txe = 2'b10;
    cnt = 0;
    // the first low sample comes at the negedge right after the trigger edge
    repeat (8) begin
      @(negedge clk) txe = 2'b00;
      cnt += (tx_rq[1] === 1'b0);
    end
    chk(8'(cnt), 8'h03);
    $display("test 3 done");
    acc(0, 0, 5'h02, 8'h07);
    d = 8'($urandom);
    rxq.push_back(d);
    ceo_seen = 1'b0;
    @(negedge clk) begin
      cei = 1'b1;
      rxv = 2'b01;
      txe = 2'b01;
      rx_bit_clock_pin = {8'h00, d};
    end
    @(negedge clk) begin
      rxv = 2'b00;
      txe = 2'b00;
    end
    repeat (4) @(negedge clk);
    chk({6'h0, rq_oe, rq}, 8'h02);
    i_host.cycle(1, 1, 5'h00, 8'h00, q, ok);
    chk({7'h0, ok}, 8'h00);
    cei = 1'b0;
    acc(1, 1, 5'h00, 8'h00); chk(q, {v[7:3], 3'b001});
    chk({7'h0, rq_oe}, 8'h01);
    acc(1, 1, 5'h00, 8'h00); chk(q, {v[7:3], 3'b010});
    chk({7'h0, ceo_seen}, 8'h00);
    i_host.cycle(1, 1, 5'h00, 8'h00, q, ok);
    chk({6'h0, ok, ceo_seen}, 8'h01);
    acc(0, 1, 5'h09, 8'h00); chk(q, 8'(rxq.pop_front()));
    $display("test 4 done");
    acc(0, 0, 5'h02, 8'h29);
    rx_pulse(2'b00);
    chk(8'(n_rxp), 8'h03);
    rx_pulse(2'b01);
    chk({7'h0, rq_oe}, 8'h01);
    acc(1, 1, 5'h00, 8'h00); chk(q, {v[7:3], 3'b000});
    rx_pulse(2'b01);
    chk(8'(n_rxp), 8'h03);
    acc(0, 0, 5'h00, CMD_CHAN_RESET);
    chk({7'h0, rq_oe}, 8'h00);
    acc(0, 0, 5'h1c, ~VEC_RESET);
    @(negedge clk) hw_n = 1'b0;
    @(negedge clk) hw_n = 1'b1;
    repeat (2) @(negedge clk);
    acc(0, 1, 5'h0c, 8'h00); chk(q, VEC_RESET);
    acc(0, 1, 5'h12, 8'h00); chk(q, RW_RESET);
    $display("test 5 done");
    close_out();
  end
endmodule
